// *** console_map.svh ***
// console_map.svh: constants of the operator console block
// How it works
// - locked: only data, sense, clear act
// - locked: no entry, compare keeps running
// - locked: clear works, match never halts
// - switch 0 is leftmost, most significant bit
// - halt: enter loads switches, then shows them
// - memory data enter writes at address register
// - halt: display shows target; instruction up inert
// - memory display read bumps address register
// - sense switch levels go to processor
// - reset clears counter, status, address, display
// - power-lost lamp set by loss, reset clears
// - running: address equals switches lights match lamp
// - clear switch darkens match lamp any mode
// - stop switch up: halt after matching instruction
// - start only in halt; run lamp tracks run
// - mode halt stops after current instruction
// - single mode: one instruction per start
// - clock on, off, step behind jumper
// - load copies 256 rom words from zero
// - after load: run mode starts, else halt
// - running: lamps show current instruction address
// - idle halt lights idle; run, reset clear
// - step pulse lasts one 250 ns period
`ifndef CONSOLE_MAP_SVH
`define CONSOLE_MAP_SVH
`define CLK_NS 5
`define STEP_NS 250
`define STEP_CYC ((`STEP_NS + `CLK_NS - 1) / `CLK_NS)
`define DEBOUNCE_NS 1000000
`define DEBOUNCE_CYC_DEF ((`DEBOUNCE_NS + `CLK_NS - 1) / `CLK_NS)
`define LOAD_WORDS 256
`define NUM_TGT 11
`define NUM_DISP 12
`define TGT_MEM_ADDR 4'h9
`define TGT_MEM_DATA 4'ha
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_LAMPS 8'h08
`define CTRL_JUMPER 0
`define STAT_RUN 0
`define STAT_IDLE 1
`define STAT_MATCH 2
`define STAT_PWR 3
`define STAT_LOCK 4
`define STAT_SINGLE 5
`define STAT_LOAD 6
`endif

// *** console_pkg.sv ***
// console_pkg.sv: types of the operator console block
package console_pkg;
  typedef enum logic [2:0] {S_HALT, S_RUN, S_SINGLE, S_LOAD, S_ACC} con_state_t;
  typedef enum logic [1:0] {K_REG_WR, K_REG_RD, K_MEM_WR, K_MEM_RD} acc_kind_t;
endpackage : console_pkg

// *** operator_console_control.sv ***
// operator_console_control.sv: switch filter and operator console logic
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "console_map.svh"

module switch_filter #(
  parameter int W = 1,
  parameter int HOLD = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] level,
  output logic [W-1:0] pulse
);
  localparam int CW = (HOLD > 1) ? $clog2(HOLD) : 1;
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
    logic [W-1:0] pls;
    logic [W-1:0][CW-1:0] cnt;
  } filt_t;
  filt_t r_reg, r_next;
  if (HOLD < 1) begin : g_bad
    $error("switch_filter: HOLD must be at least one");
  end
  always_comb begin
    r_next = r_reg;
    r_next.s1 = din;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    r_next.pls = '0;
    for (int i = 0; i < W; i++) begin
      if (r_reg.s2[i] == r_reg.s3[i] && r_reg.s3[i] != r_reg.lvl[i]) begin
        if (r_reg.cnt[i] == CW'(HOLD - 1)) begin
          r_next.lvl[i] = r_reg.s3[i];
          r_next.pls[i] = r_reg.s3[i];
          r_next.cnt[i] = '0;
        end else begin
          r_next.cnt[i] = r_reg.cnt[i] + CW'(1);
        end
      end else begin
        r_next.cnt[i] = '0;
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
  assign level = r_reg.lvl;
  assign pulse = r_reg.pls;
endmodule : switch_filter

module operator_console_control #(
  parameter int DEBOUNCE_CYC = `DEBOUNCE_CYC_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic lock_sw,
  input wire logic [0:15] data_sw,
  input wire logic [0:3] sense_sw,
  input wire logic mode_run_sw,
  input wire logic single_instruction_mode,
  input wire logic address_match_stop,
  input wire logic clock_on_sw,
  input wire logic [`NUM_TGT-1:0] enter_sw,
  input wire logic [`NUM_DISP-1:0] display_sw,
  input wire logic reset_sw,
  input wire logic match_indicator_clear,
  input wire logic step_sw,
  input wire logic load_sw,
  input wire logic start_sw,
  input wire logic [0:15] memory_address_register,
  input wire logic [0:15] cpu_pc_addr,
  input wire logic [0:15] cpu_rdata,
  input wire logic cpu_ack,
  input wire logic cpu_insn_done,
  input wire logic cpu_idle_halt,
  input wire logic mem_power_lost,
  input wire logic [0:15] rom_data,
  output logic acc_req,
  output console_pkg::acc_kind_t acc_kind,
  output logic [3:0] acc_sel,
  output logic [0:15] acc_addr,
  output logic [0:15] acc_wdata,
  output logic [7:0] rom_addr,
  output logic run_enable,
  output logic sys_clear,
  output logic clk_stop,
  output logic single_clock_pulse_request,
  output logic [0:3] sense_bits,
  output logic [0:15] data_lamps,
  output logic run_lamp,
  output logic idle_lamp,
  output logic match_lamp,
  output logic memory_power_lost_lamp
);
  import console_pkg::*;
  localparam int SCW = $clog2(`STEP_CYC + 1);
  typedef struct packed {
    con_state_t fsm;
    logic stop_pend;
    logic fetch;
    logic md_rd;
    logic md_inc;
    logic show_w;
    logic [7:0] rom_addr;
    logic acc_req;
    acc_kind_t acc_kind;
    logic [3:0] acc_sel;
    logic [0:15] acc_addr;
    logic [0:15] acc_wdata;
    logic run_enable;
    logic sys_clear;
    logic clk_stop;
    logic step;
    logic [SCW-1:0] step_cnt;
    logic [0:3] sense;
    logic [0:15] disp;
    logic [0:15] lamps;
    logic run_lamp;
    logic idle_lamp;
    logic match_lamp;
    logic pwr_lamp;
    logic jumper;
    logic a_valid;
    logic a_wr;
    logic [7:0] a_addr;
    logic [31:0] rdata;
    logic rdy;
  } con_t;
  con_t r_reg, r_next;
  logic [0:15] l_data;
  logic [0:3] l_sense;
  logic l_lock, l_bkup, l_mrun, l_msingle, l_clkon;
  logic [`NUM_TGT-1:0] p_enter;
  logic [`NUM_DISP-1:0] p_disp;
  logic p_reset, p_clr, p_step, p_load, p_start;
  logic halted, active, match, match_stop_req, reset_ok;
  logic [3:0] sel;
  if (DEBOUNCE_CYC < 1) begin : g_bad
    $error("operator_console_control: DEBOUNCE_CYC must be at least one");
  end
  switch_filter #(.W(25), .HOLD(1)) u_levels (
    .hclk(hclk),
    .hresetn(hresetn),
    .din({data_sw, sense_sw, lock_sw, address_match_stop, mode_run_sw,
          single_instruction_mode, clock_on_sw}),
    .level({l_data, l_sense, l_lock, l_bkup, l_mrun, l_msingle, l_clkon}),
    .pulse()
  );
  switch_filter #(.W(`NUM_TGT + `NUM_DISP + 5), .HOLD(DEBOUNCE_CYC)) u_moment (
    .hclk(hclk),
    .hresetn(hresetn),
    .din({enter_sw, display_sw, reset_sw, match_indicator_clear, step_sw, load_sw,
          start_sw}),
    .level(),
    .pulse({p_enter, p_disp, p_reset, p_clr, p_step, p_load, p_start})
  );

  always_comb begin
    r_next = r_reg;
    sel = '0;
    r_next.sys_clear = 1'b0;
    r_next.rdy = 1'b1;
    r_next.sense = l_sense;
    halted = r_reg.fsm == S_HALT;
    active = r_reg.fsm == S_RUN || r_reg.fsm == S_SINGLE;
    match = l_data == memory_address_register;
    match_stop_req = r_reg.fsm == S_RUN && l_bkup && match && !l_lock;
    reset_ok = p_reset && !l_lock && (halted || r_reg.fsm == S_RUN);
    if (active && match) begin
      r_next.match_lamp = 1'b1;
    end else if (p_clr) begin
      r_next.match_lamp = 1'b0;
    end
    if (mem_power_lost) begin
      r_next.pwr_lamp = 1'b1;
    end else if (reset_ok) begin
      r_next.pwr_lamp = 1'b0;
    end
    if (reset_ok) begin
      r_next.sys_clear = 1'b1;
      r_next.disp = '0;
      r_next.idle_lamp = 1'b0;
    end
    r_next.clk_stop = r_reg.jumper && !l_clkon && !l_lock;
    if (r_reg.step) begin
      if (r_reg.step_cnt == '0) begin
        r_next.step = 1'b0;
      end else begin
        r_next.step_cnt = r_reg.step_cnt - SCW'(1);
      end
    end else if (p_step && r_reg.clk_stop) begin
      r_next.step = 1'b1;
      r_next.step_cnt = SCW'(`STEP_CYC - 1);
    end
    case (r_reg.fsm)
      S_HALT: begin
        if (!l_lock) begin
          if (p_start && (l_mrun || l_msingle)) begin
            r_next.fsm = l_mrun ? S_RUN : S_SINGLE;
            r_next.run_enable = 1'b1;
            r_next.run_lamp = l_mrun;
            r_next.idle_lamp = 1'b0;
            r_next.stop_pend = 1'b0;
          end else if (p_load) begin
            r_next.fsm = S_LOAD;
            r_next.rom_addr = '0;
            r_next.fetch = 1'b1;
          end else if (|p_enter) begin
            for (int i = `NUM_TGT - 1; i >= 0; i--) begin
              if (p_enter[i]) begin
                sel = 4'(i);
              end
            end
            r_next.fsm = S_ACC;
            r_next.acc_req = 1'b1;
            r_next.acc_sel = sel;
            r_next.acc_wdata = l_data;
            r_next.show_w = 1'b1;
            r_next.acc_kind = (sel == `TGT_MEM_DATA) ? K_MEM_WR : K_REG_WR;
            r_next.acc_addr = memory_address_register;
          end else if (|p_disp) begin
            for (int i = `NUM_DISP - 1; i >= 0; i--) begin
              if (p_disp[i]) begin
                sel = 4'(i);
              end
            end
            r_next.fsm = S_ACC;
            r_next.acc_req = 1'b1;
            r_next.acc_sel = sel;
            r_next.show_w = 1'b0;
            r_next.md_rd = sel == `TGT_MEM_DATA;
            r_next.acc_kind = (sel == `TGT_MEM_DATA) ? K_MEM_RD : K_REG_RD;
            r_next.acc_addr = memory_address_register;
          end
        end
      end
      S_RUN: begin
        if (match_stop_req) begin
          r_next.stop_pend = 1'b1;
        end
        if (!l_mrun && !l_lock) begin
          r_next.stop_pend = 1'b1;
        end
        if (cpu_idle_halt) begin
          r_next.fsm = S_HALT;
          r_next.idle_lamp = 1'b1;
          r_next.run_lamp = 1'b0;
          r_next.run_enable = 1'b0;
        end else if (cpu_insn_done && (r_reg.stop_pend || (!l_mrun && !l_lock))) begin
          r_next.fsm = S_HALT;
          r_next.run_lamp = 1'b0;
          r_next.run_enable = 1'b0;
        end
      end
      S_SINGLE: begin
        if (cpu_idle_halt || cpu_insn_done) begin
          r_next.fsm = S_HALT;
          r_next.run_enable = 1'b0;
          r_next.idle_lamp = cpu_idle_halt;
        end
      end
      S_LOAD: begin
        if (!r_reg.acc_req) begin
          if (r_reg.fetch) begin
            r_next.acc_req = 1'b1;
            r_next.acc_kind = K_MEM_WR;
            r_next.acc_addr = {8'h00, r_reg.rom_addr};
            r_next.acc_wdata = rom_data;
            r_next.fetch = 1'b0;
          end
        end else if (cpu_ack) begin
          r_next.acc_req = 1'b0;
          if (r_reg.rom_addr == 8'(`LOAD_WORDS - 1)) begin
            r_next.fsm = l_mrun ? S_RUN : S_HALT;
            r_next.run_enable = l_mrun;
            r_next.run_lamp = l_mrun;
            r_next.stop_pend = 1'b0;
            if (l_mrun) begin
              r_next.idle_lamp = 1'b0;
            end
          end else begin
            r_next.rom_addr = r_reg.rom_addr + 8'h01;
            r_next.fetch = 1'b1;
          end
        end
      end
      S_ACC: begin
        if (cpu_ack) begin
          r_next.acc_req = 1'b0;
          if (r_reg.md_rd) begin
            r_next.disp = cpu_rdata;
            r_next.md_rd = 1'b0;
            r_next.md_inc = 1'b1;
            r_next.acc_req = 1'b1;
            r_next.acc_kind = K_REG_WR;
            r_next.acc_sel = `TGT_MEM_ADDR;
            r_next.acc_wdata = r_reg.acc_addr + 16'h0001;
          end else begin
            if (r_reg.show_w) begin
              r_next.disp = r_reg.acc_wdata;
            end else if (!r_reg.md_inc) begin
              r_next.disp = cpu_rdata;
            end
            r_next.md_inc = 1'b0;
            r_next.fsm = S_HALT;
          end
        end
      end
      default: begin
        r_next.fsm = S_HALT;
      end
    endcase
    r_next.lamps = active ? cpu_pc_addr : r_next.disp;
    if (hsel && htrans[1] && hready) begin
      r_next.a_valid = 1'b1;
      r_next.a_wr = hwrite;
      r_next.a_addr = haddr[7:0];
      r_next.rdata = '0;
      if (!hwrite) begin
        case (haddr[7:0])
          `OFF_CTRL: r_next.rdata[`CTRL_JUMPER] = r_reg.jumper;
          `OFF_STATUS: begin
            r_next.rdata[`STAT_RUN] = r_reg.run_lamp;
            r_next.rdata[`STAT_IDLE] = r_reg.idle_lamp;
            r_next.rdata[`STAT_MATCH] = r_reg.match_lamp;
            r_next.rdata[`STAT_PWR] = r_reg.pwr_lamp;
            r_next.rdata[`STAT_LOCK] = l_lock;
            r_next.rdata[`STAT_SINGLE] = r_reg.fsm == S_SINGLE;
            r_next.rdata[`STAT_LOAD] = r_reg.fsm == S_LOAD;
          end
          `OFF_LAMPS: r_next.rdata[15:0] = r_reg.lamps;
          default: r_next.rdata = '0;
        endcase
      end
    end else if (hready) begin
      r_next.a_valid = 1'b0;
    end
    if (r_reg.a_valid && r_reg.a_wr && r_reg.a_addr == `OFF_CTRL) begin
      r_next.jumper = hwdata[`CTRL_JUMPER];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign hrdata = r_reg.rdata;
  assign hreadyout = r_reg.rdy;
  assign hresp = r_reg.sys_clear & ~r_reg.sys_clear;
  assign acc_req = r_reg.acc_req;
  assign acc_kind = r_reg.acc_kind;
  assign acc_sel = r_reg.acc_sel;
  assign acc_addr = r_reg.acc_addr;
  assign acc_wdata = r_reg.acc_wdata;
  assign rom_addr = r_reg.rom_addr;
  assign run_enable = r_reg.run_enable;
  assign sys_clear = r_reg.sys_clear;
  assign clk_stop = r_reg.clk_stop;
  assign single_clock_pulse_request = r_reg.step;
  assign sense_bits = r_reg.sense;
  assign data_lamps = r_reg.lamps;
  assign run_lamp = r_reg.run_lamp;
  assign idle_lamp = r_reg.idle_lamp;
  assign match_lamp = r_reg.match_lamp;
  assign memory_power_lost_lamp = r_reg.pwr_lamp;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  lock_entry_a: assert property (l_lock && halted |=> r_reg.fsm == S_HALT)
    else $error("locked console left halt");
  lock_nohalt_a: assert property (l_lock && r_reg.fsm == S_RUN && !r_reg.stop_pend
    && !cpu_idle_halt |=> r_reg.fsm == S_RUN && !r_reg.stop_pend)
    else $error("match stop while locked");
  match_set_a: assert property (active && match |=> r_reg.match_lamp)
    else $error("match lamp not set");
  match_clear_a: assert property (p_clr && !(active && match) |=> !r_reg.match_lamp)
    else $error("match lamp not cleared");
  step_len_a: assert property ($rose(r_reg.step) |-> r_reg.step_cnt == SCW'(`STEP_CYC - 1))
    else $error("step pulse length wrong");
  step_end_a: assert property ($fell(r_reg.step) |-> $past(r_reg.step_cnt) == '0)
    else $error("step pulse ended early");
  single_stop_a: assert property (r_reg.fsm == S_SINGLE && cpu_insn_done
    |=> r_reg.fsm == S_HALT && !r_reg.run_enable)
    else $error("single mode ran on");
  run_lamp_a: assert property (r_reg.run_lamp |-> r_reg.fsm == S_RUN)
    else $error("run lamp outside run");
  reset_act_a: assert property (reset_ok |=> r_reg.sys_clear && r_reg.disp == '0)
    else $error("reset action missed");
  md_inc_a: assert property (r_reg.md_rd && r_reg.acc_req && cpu_ack
    |=> r_reg.acc_wdata == r_reg.acc_addr + 16'h0001 && r_reg.acc_sel == `TGT_MEM_ADDR)
    else $error("address not bumped");
  lamps_run_a: assert property (active |=> r_reg.lamps == $past(cpu_pc_addr))
    else $error("lamps not showing address");
  run_cov: cover property (halted ##1 r_reg.fsm == S_RUN);
  load_cov: cover property (r_reg.fsm == S_LOAD ##1 r_reg.fsm != S_LOAD);
  stop_cov: cover property (match_stop_req ##[1:20] halted);
  md_cov: cover property (r_reg.md_inc && cpu_ack);
endmodule : operator_console_control

// *** cpu_model.sv ***
// arithmetic unit stand-in: registers, memory, access answers, instruction timing
`timescale 1ns/1ps
module cpu_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic acc_req,
  input wire console_pkg::acc_kind_t acc_kind,
  input wire logic [3:0] acc_sel,
  input wire logic [0:15] acc_addr,
  input wire logic [0:15] acc_wdata,
  input wire logic [7:0] rom_addr,
  input wire logic run_enable,
  input wire logic sys_clear,
  input wire logic [3:0] delay,
  input wire logic idle_cmd,
  output logic [0:15] ma,
  output logic [0:15] pc,
  output logic [0:15] rdata,
  output logic ack,
  output logic insn_done,
  output logic idle_halt,
  output logic [0:15] rom_data,
  output int n_acc
);
  import console_pkg::*;
  logic [0:15] regs [0:15];
  logic [0:15] mem [0:255];
  logic [0:15] rd;
  logic [3:0] cnt;
  logic [1:0] ph;
  assign pc = regs[0];
  assign ma = regs[9];
  // read data only valid in the ack cycle
  assign rdata = ack ? rd : ~rd;
  assign rom_data = {rom_addr, ~rom_addr};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 16; i++)
        regs[i] <= '0;
      ack <= 1'b0;
      cnt <= '0;
      ph <= '0;
      insn_done <= 1'b0;
      idle_halt <= 1'b0;
      rd <= '0;
      n_acc <= 0;
    end else begin
      insn_done <= 1'b0;
      idle_halt <= 1'b0;
      ack <= 1'b0;
      if (acc_req && !ack) begin
        cnt <= cnt + 4'h1;
        if (cnt >= delay) begin
          ack <= 1'b1;
          cnt <= '0;
          n_acc <= n_acc + 1;
          case (acc_kind)
            K_REG_WR: regs[acc_sel] <= acc_wdata;
            K_REG_RD: rd <= regs[acc_sel];
            K_MEM_WR: mem[acc_addr[8:15]] <= acc_wdata;
            default: rd <= mem[acc_addr[8:15]];
          endcase
        end
      end
      if (sys_clear) begin
        regs[0] <= '0;
        regs[8] <= '0;
        regs[9] <= '0;
      end else if (run_enable && !insn_done && !idle_halt) begin
        ph <= ph + 2'h1;
        if (ph == 2'h3 && idle_cmd) begin
          idle_halt <= 1'b1;
        end else if (ph == 2'h3) begin
          insn_done <= 1'b1;
          regs[0] <= regs[0] + 16'h0001;
          regs[9] <= regs[0] + 16'h0001;
        end
      end
    end
  end
endmodule : cpu_model

// *** operator_console_control_tb.sv ***
// testbench of the operator console block
`timescale 1ns/1ps
`include "console_map.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module operator_console_control_tb;
  import console_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, lock_sw, mode_run_sw, sim, stop_sw;
  logic clock_on_sw, mem_power_lost, idle_cmd;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [0:15] data_sw, ma, pc, cpu_rdata, rom_data, acc_addr, acc_wdata, data_lamps, p;
  logic [0:3] sense_sw, sense_bits;
  logic [10:0] enter_sw;
  logic [11:0] display_sw;
  logic [4:0] mom;
  logic [3:0] delay, acc_sel;
  logic [7:0] rom_addr;
  logic hreadyout, hresp, cpu_ack, insn_done, idle_halt, acc_req, run_enable, sys_clear;
  logic clk_stop, step_pulse, run_lamp, idle_lamp, match_lamp, pwr_lamp;
  acc_kind_t acc_kind;
  int n_errors = 0, checked = 0, n_acc, n, k;
  assign hready = hreadyout;
  operator_console_control #(.DEBOUNCE_CYC(3)) operator_console_control_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .lock_sw(lock_sw), .data_sw(data_sw),
    .sense_sw(sense_sw), .mode_run_sw(mode_run_sw), .single_instruction_mode(sim),
    .address_match_stop(stop_sw), .clock_on_sw(clock_on_sw), .enter_sw(enter_sw),
    .display_sw(display_sw), .reset_sw(mom[0]), .match_indicator_clear(mom[1]),
    .step_sw(mom[2]), .load_sw(mom[3]), .start_sw(mom[4]),
    .memory_address_register(ma), .cpu_pc_addr(pc), .cpu_rdata(cpu_rdata),
    .cpu_ack(cpu_ack), .cpu_insn_done(insn_done), .cpu_idle_halt(idle_halt),
    .mem_power_lost(mem_power_lost), .rom_data(rom_data), .acc_req(acc_req),
    .acc_kind(acc_kind), .acc_sel(acc_sel), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .rom_addr(rom_addr), .run_enable(run_enable), .sys_clear(sys_clear),
    .clk_stop(clk_stop), .single_clock_pulse_request(step_pulse),
    .sense_bits(sense_bits), .data_lamps(data_lamps), .run_lamp(run_lamp),
    .idle_lamp(idle_lamp), .match_lamp(match_lamp), .memory_power_lost_lamp(pwr_lamp));
  cpu_model cpu_model_inst (
    .hclk(hclk), .hresetn(hresetn), .acc_req(acc_req), .acc_kind(acc_kind),
    .acc_sel(acc_sel), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .rom_addr(rom_addr),
    .run_enable(run_enable), .sys_clear(sys_clear), .delay(delay), .idle_cmd(idle_cmd),
    .ma(ma), .pc(pc), .rdata(cpu_rdata), .ack(cpu_ack), .insn_done(insn_done),
    .idle_halt(idle_halt), .rom_data(rom_data), .n_acc(n_acc));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task results;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task settle;
    repeat (20) @(posedge hclk);
  endtask : settle
  // one single word transfer, result in rd
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  // k 0 enter, 1 display, 2 single momentary
  task press(input int k, input int i);
    settle;
    if (k == 0) enter_sw[i] <= 1'b1;
    else if (k == 1) display_sw[i] <= 1'b1;
    else mom[i] <= 1'b1;
    settle;
    enter_sw <= '0;
    display_sw <= '0;
    mom <= '0;
    settle;
  endtask : press
  task wait_load;
    for (int i = 0; i < 4000 && cpu_model_inst.mem[255] !== 16'hff00; i++)
      @(posedge hclk);
    settle;
  endtask : wait_load
  initial begin
    repeat (60000) @(posedge hclk);
    n_errors++;
    results;
  end
  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize, lock_sw, mode_run_sw} = '0;
    {sim, stop_sw, mem_power_lost, idle_cmd, data_sw, sense_sw, enter_sw} = '0;
    {display_sw, mom} = '0;
    clock_on_sw = 1'b1;
    delay = 4'h3;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    settle;
    `CHK("run lamp", 1'b0, run_lamp)
    ahb(1'b1, `OFF_CTRL, 32'h0000_0001);
    ahb(1'b0, `OFF_CTRL, 32'h0000_0000);
    `CHK("jumper", 32'h0000_0001, rd)
    ahb(1'b0, 8'h40, 32'h0000_0000);
    `CHK("unmapped", 32'h0000_0000, rd)
    `CHK("okay", 1'b0, hresp)
    data_sw <= 16'h8001;
    press(0, 1);
    `CHK("reg a", 16'h8001, cpu_model_inst.regs[1])
    `CHK("lamps", 16'h8001, data_lamps)
    `CHK("lamp 0", 1'b1, data_lamps[0])
    ahb(1'b0, `OFF_LAMPS, 32'h0000_0000);
    `CHK("lamps reg", 32'h0000_8001, rd)
    data_sw <= 16'h0010;
    press(0, 9);
    data_sw <= 16'h1234;
    press(0, 10);
    `CHK("mem", 16'h1234, cpu_model_inst.mem[16])
    press(1, 10);
    `CHK("md lamps", 16'h1234, data_lamps)
    `CHK("ma bump", 16'h0011, ma)
    cpu_model_inst.regs[11] = 16'h5a5a;
    press(1, 11);
    `CHK("ir lamps", 16'h5a5a, data_lamps)
    press(1, 1);
    `CHK("a lamps", 16'h8001, data_lamps)
    lock_sw <= 1'b1;
    sense_sw <= 4'b1010;
    data_sw <= 16'h0077;
    press(0, 1);
    `CHK("locked enter", 16'h8001, cpu_model_inst.regs[1])
    press(2, 0);
    `CHK("locked reset", 16'h0011, ma)
    `CHK("sense", 4'b1010, sense_bits)
    ahb(1'b0, `OFF_STATUS, 32'h0000_0000);
    `CHK("status lock", 32'h0000_0010, rd)
    mode_run_sw <= 1'b1;
    press(2, 4);
    `CHK("locked start", 1'b0, run_enable)
    mode_run_sw <= 1'b0;
    lock_sw <= 1'b0;
    mem_power_lost <= 1'b1;
    settle;
    mem_power_lost <= 1'b0;
    settle;
    `CHK("pwr set", 1'b1, pwr_lamp)
    data_sw <= 16'h0040;
    press(0, 0);
    press(2, 0);
    `CHK("reset pc", 16'h0000, pc)
    `CHK("reset ma", 16'h0000, ma)
    `CHK("reset lamps", 16'h0000, data_lamps)
    `CHK("pwr clear", 1'b0, pwr_lamp)
    data_sw <= 16'h0005;
    mode_run_sw <= 1'b1;
    press(2, 4);
    `CHK("run", 1'b1, run_lamp)
    `CHK("match", 1'b1, match_lamp)
    @(negedge insn_done);
    @(posedge hclk);
    `CHK("pc lamps", pc, data_lamps)
    press(2, 1);
    `CHK("clear", 1'b0, match_lamp)
    `CHK("still run", 1'b1, run_enable)
    mode_run_sw <= 1'b0;
    settle;
    `CHK("halt", 1'b0, run_enable)
    `CHK("run dark", 1'b0, run_lamp)
    p = pc + 16'h0003;
    data_sw <= p;
    stop_sw <= 1'b1;
    mode_run_sw <= 1'b1;
    press(2, 4);
    `CHK("stop", 1'b0, run_enable)
    `CHK("stop ma", p + 16'h0001, ma)
    `CHK("stop lamp", 1'b1, match_lamp)
    stop_sw <= 1'b0;
    mode_run_sw <= 1'b0;
    sim <= 1'b1;
    press(2, 1);
    p = pc;
    press(2, 4);
    `CHK("single pc", p + 16'h0001, pc)
    `CHK("single halt", 1'b0, run_enable)
    sim <= 1'b0;
    mode_run_sw <= 1'b1;
    idle_cmd <= 1'b1;
    press(2, 4);
    `CHK("idle", 1'b1, idle_lamp)
    `CHK("idle run", 1'b0, run_lamp)
    idle_cmd <= 1'b0;
    press(2, 4);
    `CHK("idle clr", 1'b0, idle_lamp)
    lock_sw <= 1'b1;
    settle;
    stop_sw <= 1'b1;
    data_sw <= pc + 16'h0004;
    settle;
    settle;
    `CHK("locked match", 1'b1, match_lamp)
    `CHK("locked no stop", 1'b1, run_enable)
    stop_sw <= 1'b0;
    lock_sw <= 1'b0;
    mode_run_sw <= 1'b0;
    settle;
    press(2, 3);
    wait_load;
    for (int i = 0; i < 256; i++)
      `CHK("rom", {i[7:0], ~i[7:0]}, cpu_model_inst.mem[i])
    `CHK("load halt", 1'b0, run_enable)
    delay <= 4'h0;
    mode_run_sw <= 1'b1;
    cpu_model_inst.mem[255] = 16'h0000;
    press(2, 3);
    wait_load;
    `CHK("load run", 1'b1, run_enable)
    mode_run_sw <= 1'b0;
    settle;
    clock_on_sw <= 1'b0;
    settle;
    `CHK("clk off", 1'b1, clk_stop)
    mom[2] <= 1'b1;
    n = 0;
    repeat (200) begin
      @(posedge hclk);
      if (step_pulse === 1'b1) n++;
    end
    mom[2] <= 1'b0;
    `CHK("step len", `STEP_CYC, n)
    clock_on_sw <= 1'b1;
    settle;
    `CHK("clk on", 1'b0, clk_stop)
    ahb(1'b1, `OFF_CTRL, 32'h0000_0000);
    clock_on_sw <= 1'b0;
    settle;
    `CHK("no jumper", 1'b0, clk_stop)
    k = n_acc;
    enter_sw[1] <= 1'b1;
    @(posedge hclk);
    enter_sw <= '0;
    settle;
    `CHK("glitch", k, n_acc)
    press(0, 1);
    `CHK("one press", k + 1, n_acc)
    results;
  end
endmodule : operator_console_control_tb
